// ===== bench/eadec_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// decoder checks
module eadec_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic implied_i,
  input wire logic access_done_i,
  input wire eadec_pkg::eadec_form_t implied_form_i,
  input wire eadec_pkg::eadec_form_t form_o,
  input wire logic [4:0] operand_mode_field_i,
  input wire logic [1:0] operand_type_i,
  input wire logic [15:0] base_value_i,
  input wire logic [15:0] direct_address_16_i,
  input wire logic [7:0] data_bank_reg_i,
  input wire logic [7:0] program_bank_reg_i,
  input wire logic inc_we_o,
  input wire logic [2:0] inc_reg_o,
  input wire logic [15:0] inc_value_o,
  input wire logic [2:0] base_reg_o,
  input wire logic [2:0] index_reg_o,
  input wire logic index_used_o,
  input wire logic post_inc_o,
  input wire eadec_pkg::eadec_disp_t disp_width_o,
  input wire eadec_pkg::eadec_bank_t bank_sel_o,
  input wire logic [23:0] operand_address_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic e;
  logic [4:0] f;
  logic [1:0] t;
  assign e = !implied_i;
  assign f = operand_mode_field_i;
  // type 3 steps like a byte
  assign t = operand_type_i == 2'h3 ? 2'h0 : operand_type_i;
  logic [15:0] fb;
  // pointer value as the core sees it: a write still pending in the register file counts
  assign fb = inc_we_o && inc_reg_o == base_reg_o ? inc_value_o : base_value_i;
  property p_impl; implied_i |-> form_o == implied_form_i && bank_sel_o == 3'h0; endproperty
  a_impl: assert property (p_impl) else $error("implied form");
  property p_rdir; e && f < 5'h08 |-> form_o == 9'h1 && base_reg_o == f[2:0] && bank_sel_o == 3'h0; endproperty
  a_rdir: assert property (p_rdir) else $error("register direct");
  property p_ind; e && f[4:2] == 3'h2 |-> operand_address_o[15:0] == fb && base_reg_o == f[1:0]; endproperty
  a_ind: assert property (p_ind) else $error("indirect");
  property p_inc; e && access_done_i && f[4:2] == 3'h3 |=>
    inc_we_o && inc_value_o == $past(fb) + (16'h1 << $past(t)); endproperty
  a_inc: assert property (p_inc) else $error("increment");
  property p_ninc; access_done_i && !(e && f[4:2] == 3'h3) |=> !inc_we_o; endproperty
  a_ninc: assert property (p_ninc) else $error("stray write");
  property p_d8; e && f[4:3] == 2'h2 |->
    form_o == 9'h8 && base_reg_o == f[2:0] && bank_sel_o == (f[1] ? {2'h1, f[0]} : 3'h1); endproperty
  a_d8: assert property (p_d8) else $error("byte offset");
  property p_idx; e && f[4:1] == 4'hE |-> index_reg_o == 3'h7 && base_reg_o == f[0] && bank_sel_o == 3'h1; endproperty
  a_idx: assert property (p_idx) else $error("indexed");
  property p_pc; e && f == 5'h1E |-> form_o == 9'h40 && operand_address_o[23:16] == program_bank_reg_i; endproperty
  a_pc: assert property (p_pc) else $error("pc relative");
  property p_d16; e && f[4:2] == 3'h6 |-> form_o == 9'h10 && disp_width_o == 2'h2 && base_reg_o == f[1:0] &&
    bank_sel_o == (f[1] ? {2'h1, f[0]} : 3'h1); endproperty
  a_d16: assert property (p_d16) else $error("word offset");
  property p_dir; e && f == 5'h1F |->
    form_o == 9'h80 && bank_sel_o == 3'h1 && operand_address_o == {data_bank_reg_i, direct_address_16_i}; endproperty
  a_dir: assert property (p_dir) else $error("direct address");
  property p_flag; post_inc_o == (e && f[4:2] == 3'h3) && index_used_o == (e && f[4:1] == 4'hE); endproperty
  a_flag: assert property (p_flag) else $error("mode flags");
endmodule : eadec_props
bind eadec_decoder eadec_props eadec_props_i (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .implied_i(implied_i),
  .access_done_i(access_done_i),
  .implied_form_i(implied_form_i),
  .form_o(form_o),
  .operand_mode_field_i(operand_mode_field_i),
  .operand_type_i(operand_type_i),
  .base_value_i(base_value_i),
  .direct_address_16_i(direct_address_16_i),
  .data_bank_reg_i(data_bank_reg_i),
  .program_bank_reg_i(program_bank_reg_i),
  .inc_we_o(inc_we_o),
  .inc_reg_o(inc_reg_o),
  .inc_value_o(inc_value_o),
  .base_reg_o(base_reg_o),
  .index_reg_o(index_reg_o),
  .index_used_o(index_used_o),
  .post_inc_o(post_inc_o),
  .disp_width_o(disp_width_o),
  .bank_sel_o(bank_sel_o),
  .operand_address_o(operand_address_o)
);
`default_nettype wire

// ===== bench/eadec_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// core word registers
module eadec_regfile_model (
  input wire logic clk_i,
  input wire logic [2:0] rd_reg_i,
  input wire logic inc_we_i,
  input wire logic [2:0] inc_reg_i,
  input wire logic [15:0] inc_value_i,
  output logic [15:0] rd_value_o,
  output logic [15:0] idx_value_o
);
  logic [15:0] regs [8];
  // read is combinational: the decoder wants base contents in the same cycle
  assign rd_value_o = regs[rd_reg_i];
  assign idx_value_o = regs[7];
  always @(posedge clk_i) if (inc_we_i) regs[inc_reg_i] <= inc_value_i;
endmodule : eadec_regfile_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========
  // stimulus and report
  logic clk_i = 1'b0, rst_n_i = 1'b0, im, dn, iw, pw, iu, pi;
  logic [4:0] md;
  logic [1:0] ty;
  logic [2:0] br, ig, pr;
  logic [7:0] db, xb, sb, pb;
  logic [15:0] bo, wo, da, bv, xv, iv, pv;
  logic [23:0] ia, oa;
  eadec_pkg::eadec_form_t imf, fo;
  eadec_pkg::eadec_bank_t bs;
  eadec_pkg::eadec_disp_t dw;
  int seed = 32'h473D, err_count = 0, num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  eadec_decoder eadec_decoder_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .implied_i(im), .implied_form_i(imf),
    .operand_mode_field_i(md), .operand_type_i(ty), .base_value_i(bv), .index_value_i(xv), .byte_offset_i(bo),
    .word_offset_i(wo), .direct_address_16_i(da), .instr_address_i(ia), .data_bank_reg_i(db), .form_o(fo),
    .extra_data_bank_reg_i(xb), .stack_bank_reg_i(sb), .program_bank_reg_i(pb), .access_done_i(dn),
    .base_reg_o(br), .index_reg_o(), .index_used_o(iu), .disp_width_o(dw), .post_inc_o(pi), .bank_sel_o(bs),
    .operand_address_o(oa), .inc_we_o(iw), .inc_reg_o(ig), .inc_value_o(iv));
  eadec_regfile_model eadec_regfile_model_i (.clk_i(clk_i), .rd_reg_i(br), .inc_we_i(iw), .inc_reg_i(ig),
    .inc_value_i(iv), .rd_value_o(bv), .idx_value_o(xv));
  task automatic check(input string nm, input logic [38:0] s, input logic [38:0] x);
    num_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  // pointer as the core sees it: the increment from the previous access is still on its way in
  function automatic logic [15:0] rv(input logic [2:0] r);
    return pw && pr == r ? pv : eadec_regfile_model_i.regs[r];
  endfunction : rv
  function automatic logic [38:0] ev(input logic [4:0] c);
    logic [2:0] k, r;
    logic [15:0] b, o;
    logic [3:0] s;
    r = c[4:3] == 2'h2 ? c[2:0] : {1'b0, c[1:0]};
    b = rv(r);
    k = c > 5'h1B ? (c == 5'h1E ? 3'h4 : 3'h1) : c[1] ? {2'h1, c[0]} : 3'h1;
    s = c < 5'h10 ? {3'h0, c[2]} + 4'h1 : c < 5'h18 ? 4'h3 : c < 5'h1C ? 4'h4 : 4'h5 + 4'(c > 5'h1D) + 4'(c > 5'h1E);
    o = s == 4'h3 ? b + {{8{bo[7]}}, bo[7:0]} : s == 4'h4 ? b + wo : s == 4'h5 ? b + xv : b;
    o = s == 4'h6 ? ia[15:0] + 16'h4 + wo : s == 4'h7 ? da : o;
    if (im) return {imf, 30'h0};
    if (c < 5'h08) return {9'h1, 3'h0, c[2:0], 24'h0};
    return {9'h1 << s, k, s > 4'h5 ? 3'h0 : r, k == 3'h1 ? db : k == 3'h2 ? xb : k == 3'h3 ? sb : pb, o};
  endfunction : ev
  task automatic step(input logic [4:0] c, input logic [1:0] t, input logic d, input logic i);
    logic [3:0] fx;
    @(posedge clk_i);
    #1;
    {md, ty, dn, im} = {c, t, d, i};
    {bo, wo} = $random(seed);
    {da, db, pb} = $random(seed);
    {ia, xb} = $random(seed);
    sb = 8'($random(seed));
    imf = eadec_pkg::eadec_form_t'(9'h1 << ({$random(seed)} % 9));
    check("increment", {iw, iw ? {ig, iv} : 19'h0}, {pw, pw ? {pr, pv} : 19'h0});
    #1;
    check("decode", {fo, bs, im || c > 5'h1D ? 3'h0 : br, im || c < 5'h08 ? 24'h0 : oa}, ev(c));
    fx = {i ? 2'h0 : c[4:3] == 2'h2 ? 2'h1 : c[4:2] == 3'h6 || c == 5'h1E ? 2'h2 : 2'h0,
      !i && c[4:2] == 3'h3, !i && c[4:1] == 4'hE};
    check("flags", {dw, pi, iu}, fx);
    pv = rv({1'b0, c[1:0]}) + (16'h1 << (t == 2'h3 ? 2'h0 : t));
    {pw, pr} = {d && !i && c[4:2] == 3'h3, 1'b0, c[1:0]};
  endtask : step
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    {im, dn, md, ty, bo, wo, da, ia, db, xb, sb, pb, pw} = 0;
    imf = eadec_pkg::EADEC_FORM_IMPLIED;
    // pointers just under the top so post-increments wrap
    for (int k = 0; k < 8; k++) eadec_regfile_model_i.regs[k] = 16'hFFFF - 16'(k);
    repeat (16) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    for (int c = 0; c < 96; c++) step(5'(c), 2'(c / 32), 1'b1, 1'b0);
    repeat (3) step(5'h0C, 2'h2, 1'b1, 1'b0);
    $display("code sweep done");
    repeat (400) step(5'($random(seed)), 2'($random(seed)), 1'($random(seed)), $random(seed) % 8 == 0);
    step(5'h0, 2'h0, 1'b0, 1'b0);
    $display("random run done");
    close_out();
  end
endmodule : testbench
`default_nettype wire

// ===== verilog/eadec_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - form from field, or implied from opcode
// RULE_02 - codes 00-07 register direct, no bank
// RULE_03 - codes 08-0B indirect via word regs 0-3
// RULE_04 - codes 0C-0F indirect with post-increment
// RULE_05 - codes 10-17 indirect plus byte offset
// RULE_06 - codes 18-1B indirect plus word offset
// RULE_07 - codes 1C/1D word reg 0/1 plus 7
// RULE_08 - code 1E pc relative, program bank
// RULE_09 - code 1F direct 16-bit address, data bank
// RULE_10 - post-increment adds 1, 2 or 4
// RULE_11 - offsets sign-extended, added signed
// RULE_12 - pc relative: instruction address plus four plus offset
// RULE_13 - bank supplies bits 23:16, offset lower bits
// RULE_14 - decode outputs combinational in same cycle
module eadec_decoder (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic implied_i,
  input wire eadec_pkg::eadec_form_t implied_form_i,
  input wire logic [4:0] operand_mode_field_i,
  input wire logic [1:0] operand_type_i,
  input wire logic [15:0] base_value_i,
  input wire logic [15:0] index_value_i,
  input wire logic [15:0] byte_offset_i,
  input wire logic [15:0] word_offset_i,
  input wire logic [15:0] direct_address_16_i,
  input wire logic [23:0] instr_address_i,
  input wire logic [7:0] data_bank_reg_i,
  input wire logic [7:0] extra_data_bank_reg_i,
  input wire logic [7:0] stack_bank_reg_i,
  input wire logic [7:0] program_bank_reg_i,
  input wire logic access_done_i,
  output var eadec_pkg::eadec_form_t form_o,
  output logic [2:0] base_reg_o,
  output logic [2:0] index_reg_o,
  output logic index_used_o,
  output var eadec_pkg::eadec_disp_t disp_width_o,
  output logic post_inc_o,
  output var eadec_pkg::eadec_bank_t bank_sel_o,
  output logic [23:0] operand_address_o,
  output logic inc_we_o,
  output logic [2:0] inc_reg_o,
  output logic [15:0] inc_value_o
);

  // ==========================================================
  // state: pending post-increment write-back
  typedef struct packed {
    logic inc_we;
    logic [2:0] inc_reg;
    logic [15:0] inc_value;
  } eadec_state_t;

  eadec_state_t state_q;
  eadec_state_t state_d;
  logic [15:0] step;
  logic [15:0] offset;
  logic [15:0] base_eff;
  logic [7:0] bank;

  // ==========================================================
  // field decode
  always_comb
  begin
    form_o = eadec_pkg::EADEC_FORM_REG_DIRECT;
    base_reg_o = operand_mode_field_i[2:0];
    index_reg_o = eadec_pkg::EADEC_INDEX_REG;
    index_used_o = 1'b0;
    disp_width_o = eadec_pkg::EADEC_DISP_NONE;
    post_inc_o = 1'b0;
    bank_sel_o = eadec_pkg::EADEC_BANK_NONE;
    // bank pattern per low two bits: data, data, extra, stack
    unique case (operand_mode_field_i[1:0])
      2'h2: bank_sel_o = eadec_pkg::EADEC_BANK_EXTRA;
      2'h3: bank_sel_o = eadec_pkg::EADEC_BANK_STACK;
      default: bank_sel_o = eadec_pkg::EADEC_BANK_DATA;
    endcase
    if (operand_mode_field_i < eadec_pkg::EADEC_CODE_IND_LO)
    begin
      // operand width comes from operand_type_i at the register file
      bank_sel_o = eadec_pkg::EADEC_BANK_NONE; // see RULE_02
    end
    else if (operand_mode_field_i < eadec_pkg::EADEC_CODE_INC_LO)
    begin
      form_o = eadec_pkg::EADEC_FORM_INDIRECT; // see RULE_03
      base_reg_o = {1'b0, operand_mode_field_i[1:0]};
    end
    else if (operand_mode_field_i < eadec_pkg::EADEC_CODE_D8_LO)
    begin
      form_o = eadec_pkg::EADEC_FORM_POST_INC; // see RULE_04
      base_reg_o = {1'b0, operand_mode_field_i[1:0]};
      post_inc_o = 1'b1;
    end
    else if (operand_mode_field_i < eadec_pkg::EADEC_CODE_D16_LO)
    begin
      form_o = eadec_pkg::EADEC_FORM_BYTE_OFFSET; // see RULE_05
      disp_width_o = eadec_pkg::EADEC_DISP_8;
    end
    else if (operand_mode_field_i < eadec_pkg::EADEC_CODE_IDX0)
    begin
      form_o = eadec_pkg::EADEC_FORM_WORD_OFFSET; // see RULE_06
      base_reg_o = {1'b0, operand_mode_field_i[1:0]};
      disp_width_o = eadec_pkg::EADEC_DISP_16;
    end
    else if (operand_mode_field_i == eadec_pkg::EADEC_CODE_IDX0 ||
             operand_mode_field_i == eadec_pkg::EADEC_CODE_IDX1)
    begin
      form_o = eadec_pkg::EADEC_FORM_INDEXED; // see RULE_07
      base_reg_o = {2'h0, operand_mode_field_i[0]};
      index_used_o = 1'b1;
      bank_sel_o = eadec_pkg::EADEC_BANK_DATA;
    end
    else if (operand_mode_field_i == eadec_pkg::EADEC_CODE_PCREL)
    begin
      form_o = eadec_pkg::EADEC_FORM_PC_REL; // see RULE_08
      disp_width_o = eadec_pkg::EADEC_DISP_16;
      bank_sel_o = eadec_pkg::EADEC_BANK_PROG;
    end
    else
    begin
      form_o = eadec_pkg::EADEC_FORM_DIRECT; // see RULE_09
      bank_sel_o = eadec_pkg::EADEC_BANK_DATA;
    end
    // implied addressing overrides form, flags and bank select; base_reg_o still follows the field
    if (implied_i)
    begin
      form_o = implied_form_i; // see RULE_01
      disp_width_o = eadec_pkg::EADEC_DISP_NONE;
      post_inc_o = 1'b0;
      index_used_o = 1'b0;
      bank_sel_o = eadec_pkg::EADEC_BANK_NONE;
    end
  end

  // ==========================================================
  // base forwarding
  // the register file takes a pending increment one edge after it is registered,
  // so a back-to-back access through the same pointer would read a stale value;
  // only one write is ever in flight, so one stage of forwarding is enough
  always_comb
  begin
    base_eff = base_value_i;
    if (state_q.inc_we && state_q.inc_reg == base_reg_o)
    begin
      base_eff = state_q.inc_value; // see RULE_10
    end
  end

  // ==========================================================
  // operand address generation
  always_comb
  begin
    offset = base_eff;
    unique case (form_o)
      eadec_pkg::EADEC_FORM_BYTE_OFFSET:
        offset = base_eff + {{8{byte_offset_i[7]}}, byte_offset_i[7:0]}; // see RULE_11
      eadec_pkg::EADEC_FORM_WORD_OFFSET:
        offset = base_eff + word_offset_i; // see RULE_11
      eadec_pkg::EADEC_FORM_INDEXED:
        offset = base_eff + index_value_i; // see RULE_07
      eadec_pkg::EADEC_FORM_PC_REL:
        // wraps within the bank, no carry into bits 23:16
        offset = instr_address_i[15:0] + eadec_pkg::EADEC_PC_BIAS + word_offset_i; // see RULE_12
      eadec_pkg::EADEC_FORM_DIRECT:
        offset = direct_address_16_i; // see RULE_09
      default:
        offset = base_eff;
    endcase
  end

  // ==========================================================
  // bank select and address assembly
  // register direct selects no bank, its address output is meaningless
  always_comb
  begin
    unique case (bank_sel_o)
      eadec_pkg::EADEC_BANK_DATA: bank = data_bank_reg_i;
      eadec_pkg::EADEC_BANK_EXTRA: bank = extra_data_bank_reg_i;
      eadec_pkg::EADEC_BANK_STACK: bank = stack_bank_reg_i;
      eadec_pkg::EADEC_BANK_PROG: bank = program_bank_reg_i;
      default: bank = 8'h00;
    endcase
    operand_address_o = {bank, offset}; // see RULE_13, RULE_14
  end

  // ==========================================================
  // post-increment write-back, one cycle after the access
  always_comb
  begin
    unique case (operand_type_i)
      eadec_pkg::EADEC_OPT_LONG: step = eadec_pkg::EADEC_INC_LONG;
      eadec_pkg::EADEC_OPT_WORD: step = eadec_pkg::EADEC_INC_WORD;
      default: step = eadec_pkg::EADEC_INC_BYTE;
    endcase
    state_d = state_q;
    state_d.inc_we = access_done_i && post_inc_o; // see RULE_10
    if (access_done_i && post_inc_o)
    begin
      state_d.inc_reg = base_reg_o;
      state_d.inc_value = base_eff + step; // see RULE_10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign inc_we_o = state_q.inc_we;
  assign inc_reg_o = state_q.inc_reg;
  assign inc_value_o = state_q.inc_value;

endmodule : eadec_decoder

`default_nettype wire

// ===== verilog/eadec_pkg.sv
package eadec_pkg;
  // ==========================================================
  // addressing forms, one-hot
  typedef enum logic [8:0] {
    EADEC_FORM_REG_DIRECT = 9'h001,
    EADEC_FORM_INDIRECT   = 9'h002,
    EADEC_FORM_POST_INC   = 9'h004,
    EADEC_FORM_BYTE_OFFSET      = 9'h008,
    EADEC_FORM_WORD_OFFSET     = 9'h010,
    EADEC_FORM_INDEXED    = 9'h020,
    EADEC_FORM_PC_REL     = 9'h040,
    EADEC_FORM_DIRECT     = 9'h080,
    EADEC_FORM_IMPLIED    = 9'h100
  } eadec_form_t;

  // ==========================================================
  // default bank select
  typedef enum logic [2:0] {
    EADEC_BANK_NONE  = 3'h0,
    EADEC_BANK_DATA  = 3'h1,
    EADEC_BANK_EXTRA = 3'h2,
    EADEC_BANK_STACK = 3'h3,
    EADEC_BANK_PROG  = 3'h4
  } eadec_bank_t;

  // ==========================================================
  // displacement width
  typedef enum logic [1:0] {
    EADEC_DISP_NONE = 2'h0,
    EADEC_DISP_8    = 2'h1,
    EADEC_DISP_16   = 2'h2
  } eadec_disp_t;

  // operand type
  localparam logic [1:0] EADEC_OPT_BYTE = 2'h0;
  localparam logic [1:0] EADEC_OPT_WORD = 2'h1;
  localparam logic [1:0] EADEC_OPT_LONG = 2'h2;

  // field code boundaries
  localparam logic [4:0] EADEC_CODE_IND_LO = 5'h08;
  localparam logic [4:0] EADEC_CODE_INC_LO = 5'h0C;
  localparam logic [4:0] EADEC_CODE_D8_LO = 5'h10;
  localparam logic [4:0] EADEC_CODE_D16_LO = 5'h18;
  localparam logic [4:0] EADEC_CODE_IDX0 = 5'h1C;
  localparam logic [4:0] EADEC_CODE_IDX1 = 5'h1D;
  localparam logic [4:0] EADEC_CODE_PCREL = 5'h1E;
  localparam logic [4:0] EADEC_CODE_DIRECT = 5'h1F;

  localparam logic [2:0] EADEC_INDEX_REG = 3'h7;
  localparam logic [15:0] EADEC_PC_BIAS = 16'h0004;
  localparam logic [15:0] EADEC_INC_BYTE = 16'h0001;
  localparam logic [15:0] EADEC_INC_WORD = 16'h0002;
  localparam logic [15:0] EADEC_INC_LONG = 16'h0004;
endpackage : eadec_pkg
